// ### snooze_pkg.sv
// constants, state codes and register map of the snooze wake sequencer
package snooze_pkg;

   // ****************************************
   // register map (plain port, byte wide)
   // ****************************************
   localparam logic [2:0] ctrl_off   = 3'h0;
   localparam logic [2:0] upper_off  = 3'h1;
   localparam logic [2:0] lower_off  = 3'h2;
   localparam logic [2:0] cmp_off    = 3'h3;
   localparam logic [2:0] status_off = 3'h4;
   localparam logic [2:0] rxdata_off = 3'h5;

   // control register fields
   localparam int conv_wake_bit  = 0;
   localparam int ser_wake_bit   = 1;
   localparam int mode_req_bit   = 2;
   localparam int act_high_bit   = 3;
   localparam int pin_sel_lsb    = 4;
   localparam int xfer_en_bit    = 7;

   // status register fields
   localparam int st_mode_bit    = 0;
   localparam int st_hazard_bit  = 1;
   localparam int st_range_bit   = 2;
   localparam int st_wden_bit    = 3;
   localparam int st_wdsb_bit    = 4;
   localparam int st_snooze_bit  = 5;
   localparam int st_stop_bit    = 6;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [7:0] ctrl_rst   = 8'h08;
   localparam logic [7:0] upper_rst  = 8'hFF;
   localparam logic [7:0] lower_rst  = 8'h00;
   localparam logic [7:0] cmp_rst    = 8'h00;
   localparam logic [7:0] rxdata_rst = 8'h00;
   localparam logic [1:0] pins_rst   = 2'h1;

   // synchroniser stages for pin inputs
   localparam int sync_stages = 3;

   // one-hot power states
   typedef enum logic [4:0] {
      st_run      = 5'h01,
      st_stop     = 5'h02,
      st_snz_conv = 5'h04,
      st_snz_rx   = 5'h08,
      st_snz_xfer = 5'h10
   } pstate_e;

endpackage : snooze_pkg

// ### pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
   parameter int         W       = 2,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   import snooze_pkg::*;

   // the three stages and the filtered output kept as one state word
   typedef struct packed {
      logic [sync_stages-1:0][W-1:0] stage;
      logic [W-1:0]                  out;
   } sync_s;

   sync_s q, d;

   // stage one is read by stage two only; output moves when two and three agree
   always_comb begin
      d          = q;
      d.stage[0] = pin_in;
      for (int i = 1; i < sync_stages; i++) begin
         d.stage[i] = q.stage[i-1];
      end
      for (int b = 0; b < W; b++) begin
         if (q.stage[1][b] == q.stage[2][b]) begin
            d.out[b] = q.stage[2][b];
         end
      end
      // idle levels at reset, so no false edge follows its release
      if (rst) begin
         d.stage = {sync_stages{RST_VAL}};
         d.out   = RST_VAL;
      end
   end

   // single state register
   always_ff @(posedge sys_clk) begin
      q <= d;
   end

   assign pin_out = q.out;

endmodule : pin_sync

// ### snooze_wake_sequencer.sv
// snooze wake sequencer: stop/snooze/run control and wake decisions
`timescale 1ns/100ps
module snooze_wake_sequencer (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       stop_req,
   input  wire logic       interval_timer_irq,
   input  wire logic       waveform_timer_irq,
   input  wire logic       serial_rx_pin,
   input  wire logic       external_pin_irq,
   input  wire logic       conv_done,
   input  wire logic [7:0] conv_result,
   input  wire logic       rx_done,
   input  wire logic [7:0] rx_byte,
   input  wire logic       xfer_done,
   input  wire logic       watchdog_enable_option,
   input  wire logic       watchdog_standby_option,
   input  wire logic       fast_osc_range_select,
   output logic            cpu_clk_en,
   output logic            fast_osc_en,
   output logic            slow_osc_en,
   output logic            wdt_osc_en,
   output logic            wdt_clear,
   output logic            conv_start,
   output logic            rx_start,
   output logic            xfer_req,
   output logic            conversion_done_irq,
   output logic            serial_rx_irq,
   output logic            range_high,
   output logic      [7:0] snooze_status_pin
);
   import snooze_pkg::*;

   // ****************************************
   // state of the block
   // ****************************************
   typedef struct packed {
      pstate_e    st;
      logic [7:0] ctrl;
      logic [7:0] upper;
      logic [7:0] lower;
      logic [7:0] cmp;
      logic [7:0] rxdata;
      logic [7:0] rdata;
      logic       mode_stat;
      logic       hazard;
      logic       opt_ok;
      logic       wd_en;
      logic       wd_sb;
      logic       range;
      logic       rx_prev;
      logic       conv_irq;
      logic       rx_irq;
      logic       c_start;
      logic       r_start;
      logic       x_req;
      logic       wd_clr;
      logic [7:0] pins;
   } seq_s;

   seq_s q, d;
   logic [1:0] pins_s;
   logic       rx_s;
   logic       ext_s;
   logic       rx_fall;

   // true while in any snooze state
   function automatic logic in_snooze(input pstate_e s);
      return (s == st_snz_conv) || (s == st_snz_rx) || (s == st_snz_xfer);
   endfunction : in_snooze

   // conversion result outside the programmed window
   function automatic logic out_window(input logic [7:0] r, lo, hi);
      return (r < lo) || (r > hi);
   endfunction : out_window

   // rx idles high, external request idles low
   pin_sync #(
      .W       (2),
      .RST_VAL (pins_rst)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  ({external_pin_irq, serial_rx_pin}),
      .pin_out (pins_s)
   );

   assign rx_s    = pins_s[0];
   assign ext_s   = pins_s[1];
   assign rx_fall = q.rx_prev & ~rx_s;

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      d         = q;
      d.rx_prev = rx_s;
      d.conv_irq = 1'b0;
      d.rx_irq  = 1'b0;
      d.c_start = 1'b0;
      d.r_start = 1'b0;
      d.x_req   = 1'b0;
      d.wd_clr  = 1'b0;
      // serial mode status trails its request by one cycle
      d.mode_stat = q.ctrl[mode_req_bit];

      // options are caught once, right after reset release
      if (!q.opt_ok) begin
         d.opt_ok = 1'b1;
         d.wd_en  = watchdog_enable_option;
         d.wd_sb  = watchdog_standby_option;
         d.range  = fast_osc_range_select;
      end

      // register writes
      if (wr) begin
         case (addr)
            ctrl_off:  d.ctrl  = wdata;
            upper_off: d.upper = wdata;
            lower_off: d.lower = wdata;
            cmp_off:   d.cmp   = wdata;
            status_off: begin
               if (wdata[st_hazard_bit]) d.hazard = 1'b0;
            end
            default: ;
         endcase
      end

      // register reads, data one cycle later; unmapped reads zero
      d.rdata = 8'h00;
      if (rd) begin
         case (addr)
            ctrl_off:   d.rdata = q.ctrl;
            upper_off:  d.rdata = q.upper;
            lower_off:  d.rdata = q.lower;
            cmp_off:    d.rdata = q.cmp;
            rxdata_off: d.rdata = q.rxdata;
            status_off: begin
               d.rdata[st_mode_bit]   = q.mode_stat;
               d.rdata[st_hazard_bit] = q.hazard;
               d.rdata[st_range_bit]  = q.range;
               d.rdata[st_wden_bit]   = q.wd_en;
               d.rdata[st_wdsb_bit]   = q.wd_sb;
               d.rdata[st_snooze_bit] = in_snooze(q.st);
               d.rdata[st_stop_bit]   = (q.st == st_stop);
            end
            default: d.rdata = 8'h00;
         endcase
      end

      // a start edge outside stop and serial snooze with the serial enable set is flagged;
      // set beats a same-cycle software clear
      if (rx_fall && q.ctrl[ser_wake_bit] && q.st != st_stop && q.st != st_snz_rx) begin
         d.hazard = 1'b1;
      end

      // power state machine
      case (q.st)
         st_run: begin
            if (stop_req) d.st = st_stop;
         end
         st_stop: begin
            // snooze is reached from stop only
            if (ext_s) begin
               d.st = st_run;
            end else if (q.ctrl[conv_wake_bit] &&
                         (interval_timer_irq || waveform_timer_irq)) begin
               d.st      = st_snz_conv;
               d.c_start = 1'b1;
            end else if (q.ctrl[ser_wake_bit] && rx_fall) begin
               d.st      = st_snz_rx;
               d.r_start = 1'b1;
            end else if (q.ctrl[xfer_en_bit] && interval_timer_irq) begin
               d.st    = st_snz_xfer;
               d.x_req = 1'b1;
            end
         end
         st_snz_conv: begin
            if (conv_done) begin
               if (out_window(conv_result, q.lower, q.upper)) begin
                  d.conv_irq = 1'b1;
                  d.st       = st_run;
               end else begin
                  d.st = st_stop;
               end
            end
         end
         st_snz_rx: begin
            if (rx_done) begin
               d.rxdata = rx_byte;
               if (rx_byte == q.cmp) begin
                  d.rx_irq = 1'b1;
                  d.st     = st_run;
               end else begin
                  d.st = st_stop;
               end
            end
         end
         st_snz_xfer: begin
            // transfers run without the cpu; only the pin wakes it
            if (ext_s) begin
               d.st = st_run;
            end else if (xfer_done) begin
               d.st = st_stop;
            end
         end
         default: d.st = st_run;
      endcase

      // a watchdog that slept is cleared on return to run
      if (d.st == st_run && q.st != st_run && q.wd_en && !q.wd_sb) begin
         d.wd_clr = 1'b1;
      end

      // status pin: selected pin active in snooze, all idle otherwise
      for (int i = 0; i < 8; i++) begin
         if (in_snooze(d.st) && q.ctrl[pin_sel_lsb +: 3] == 3'(i)) begin
            d.pins[i] = q.ctrl[act_high_bit];
         end else begin
            d.pins[i] = ~q.ctrl[act_high_bit];
         end
      end

      // reset returns every field to its idle value at once
      if (rst) begin
         d.st       = st_run;
         d.ctrl     = ctrl_rst;
         d.upper    = upper_rst;
         d.lower    = lower_rst;
         d.cmp      = cmp_rst;
         d.rxdata   = rxdata_rst;
         d.rdata    = 8'h00;
         d.mode_stat = 1'b0;
         d.hazard   = 1'b0;
         d.opt_ok   = 1'b0;
         d.wd_en    = 1'b0;
         d.wd_sb    = 1'b0;
         d.range    = 1'b0;
         d.rx_prev  = 1'b1;
         d.conv_irq = 1'b0;
         d.rx_irq   = 1'b0;
         d.c_start  = 1'b0;
         d.r_start  = 1'b0;
         d.x_req    = 1'b0;
         d.wd_clr   = 1'b0;
         d.pins     = ~{8{ctrl_rst[act_high_bit]}};
      end
   end

   // single state register, synchronous reset handled above
   always_ff @(posedge sys_clk) begin
      q <= d;
   end

   // ****************************************
   // outputs
   // ****************************************
   // clocks follow the registered state so they never glitch mid-cycle
   assign cpu_clk_en  = (q.st == st_run);
   assign fast_osc_en = (q.st != st_stop);
   assign slow_osc_en = 1'b1;                              // trigger timer keeps counting
   assign wdt_osc_en  = q.wd_en & (cpu_clk_en | q.wd_sb);
   assign wdt_clear   = q.wd_clr;
   assign conv_start  = q.c_start;
   assign rx_start    = q.r_start;
   assign xfer_req    = q.x_req;
   assign conversion_done_irq = q.conv_irq;
   assign serial_rx_irq = q.rx_irq;
   assign range_high  = q.range;
   assign snooze_status_pin = q.pins;
   assign rdata       = q.rdata;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_stop_clocks_off: assert property (
      q.st == st_stop |-> !cpu_clk_en && !fast_osc_en)
      else $error("clocks running in stop");

   a_conv_trigger: assert property (
      q.st == st_stop && !ext_s && q.ctrl[conv_wake_bit] && interval_timer_irq
      |=> q.st == st_snz_conv && conv_start && fast_osc_en)
      else $error("conversion trigger not taken");

   a_conv_inside: assert property (
      q.st == st_snz_conv && conv_done && !out_window(conv_result, q.lower, q.upper)
      |=> q.st == st_stop && !conversion_done_irq)
      else $error("inside window did not return to stop");

   a_conv_outside: assert property (
      q.st == st_snz_conv && conv_done && out_window(conv_result, q.lower, q.upper)
      |=> conversion_done_irq && cpu_clk_en ##1 !conversion_done_irq)
      else $error("outside window did not wake");

   a_rx_mismatch: assert property (
      q.st == st_snz_rx && rx_done && rx_byte != q.cmp
      |=> q.st == st_stop && !serial_rx_irq)
      else $error("mismatch did not return to stop");

   a_rx_match: assert property (
      q.st == st_snz_rx && rx_done && rx_byte == q.cmp
      |=> serial_rx_irq && q.st == st_run && q.rxdata == $past(rx_byte))
      else $error("match did not wake");

   a_xfer_quiet: assert property (
      q.st == st_snz_xfer && xfer_done && !ext_s |=> q.st == st_stop && !cpu_clk_en)
      else $error("transfer woke the cpu");

   a_snooze_entry: assert property (
      !in_snooze(q.st) ##1 in_snooze(q.st) |-> $past(q.st) == st_stop)
      else $error("snooze entered from outside stop");

   a_status_pin: assert property (
      in_snooze(q.st) && $stable(q.ctrl) |->
         snooze_status_pin[q.ctrl[pin_sel_lsb +: 3]] == q.ctrl[act_high_bit])
      else $error("status pin not active in snooze");

   a_pin_idle: assert property (
      !in_snooze(q.st) && $stable(q.ctrl) |->
         snooze_status_pin == {8{~q.ctrl[act_high_bit]}})
      else $error("status pin active outside snooze");

   a_wdt_clear: assert property (
      q.st != st_run && d.st == st_run && q.wd_en && !q.wd_sb |=> wdt_clear)
      else $error("watchdog not cleared on wake");

   a_reset_release: assert property (
      disable iff (1'b0) rst |=> q.st == st_run && !in_snooze(q.st))
      else $error("reset did not release snooze");

   c_conv_return: cover property (q.st == st_snz_conv ##1 q.st == st_stop);
   c_conv_wake: cover property (conversion_done_irq);
   c_rx_wake: cover property (serial_rx_irq);
   c_xfer_run: cover property (q.st == st_snz_xfer ##1 q.st == st_run);

endmodule : snooze_wake_sequencer

// ### periph_model.sv
// converter, receiver and transfer unit answering the sequencer
`timescale 1ns/100ps
module periph_model #(
   parameter int lat = 12
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       conv_start,
   input  wire logic       rx_start,
   input  wire logic       xfer_req,
   input  wire logic [7:0] conv_value,
   input  wire logic [7:0] rx_value,
   output logic            conv_done = 1'b0,
   output logic      [7:0] conv_result = 8'h00,
   output logic            rx_done = 1'b0,
   output logic      [7:0] rx_byte = 8'h00,
   output logic            xfer_done = 1'b0
);
   logic [2:0] kind_q = 3'h0;
   int         cnt_q = 0;

   // ****************************************
   // answer each start after lat cycles
   // ****************************************
   // data lines toggle while not valid, so a stale byte never looks fresh
   always @(posedge sys_clk) begin
      conv_done <= 1'b0;
      rx_done <= 1'b0;
      xfer_done <= 1'b0;
      conv_result <= ~conv_result;
      rx_byte <= ~rx_byte;
      if (rst) begin
         cnt_q <= 0;
      end else if (conv_start | rx_start | xfer_req) begin
         cnt_q <= lat;
         kind_q <= {xfer_req, rx_start, conv_start};
      end else if (cnt_q == 1) begin
         cnt_q <= 0;
         conv_done <= kind_q[0];
         rx_done <= kind_q[1];
         xfer_done <= kind_q[2];
         if (kind_q[0]) conv_result <= conv_value;
         if (kind_q[1]) rx_byte <= rx_value;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
endmodule : periph_model

// ### tb.sv
// testbench of the snooze wake sequencer
`timescale 1ns/100ps
module tb;
   import snooze_pkg::*;
   localparam int lat = 12;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic stop_req = 1'b0;
   logic interval_timer_irq = 1'b0;
   logic waveform_timer_irq = 1'b0;
   logic serial_rx_pin = 1'b1;
   logic external_pin_irq = 1'b0;
   logic wd_sb_opt = 1'b0;
   logic range_opt = 1'b1;
   logic [7:0] conv_value = 8'h00;
   logic [7:0] rx_value = 8'h00;
   logic conv_done, rx_done, xfer_done, cpu_clk_en, fast_osc_en;
   logic slow_osc_en, wdt_osc_en, wdt_clear, conv_start, rx_start;
   logic xfer_req, conversion_done_irq, serial_rx_irq, range_high;
   logic [7:0] conv_result, rx_byte, rdata, snooze_status_pin, rv;
   logic [7:0] rst_tab [8] = '{8'h08, 8'hFF, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00};
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n_conv = 0, n_rx = 0, n_xfer = 0, n_ci = 0, n_si = 0, n_wc = 0;

   snooze_wake_sequencer u_snooze_wake_sequencer (
      .sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .stop_req,
      .interval_timer_irq, .waveform_timer_irq, .serial_rx_pin,
      .external_pin_irq, .conv_done, .conv_result, .rx_done, .rx_byte,
      .xfer_done, .watchdog_enable_option(1'b1),
      .watchdog_standby_option(wd_sb_opt), .fast_osc_range_select(range_opt),
      .cpu_clk_en, .fast_osc_en, .slow_osc_en, .wdt_osc_en, .wdt_clear,
      .conv_start, .rx_start, .xfer_req, .conversion_done_irq,
      .serial_rx_irq, .range_high, .snooze_status_pin);

   periph_model #(.lat(lat)) u_periph_model (
      .sys_clk, .rst, .conv_start, .rx_start, .xfer_req, .conv_value,
      .rx_value, .conv_done, .conv_result, .rx_done, .rx_byte, .xfer_done);

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // ****************************************
   // pulse tallies and hang guard
   // ****************************************
   always @(posedge sys_clk) begin
      cyc++;
      if (!rst) begin
         n_conv += int'(conv_start);
         n_rx += int'(rx_start);
         n_xfer += int'(xfer_req);
         n_ci += int'(conversion_done_irq);
         n_si += int'(serial_rx_irq);
         n_wc += int'(wdt_clear);
      end
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd_reg(a, v);
      chk(v, e);
   endtask : rd_chk

   // one-cycle event: 0 stop, 1 interval timer, 2 waveform timer
   task automatic fire(input int k);
      @(posedge sys_clk);
      stop_req <= (k == 0);
      interval_timer_irq <= (k == 1);
      waveform_timer_irq <= (k == 2);
      @(posedge sys_clk);
      stop_req <= 1'b0;
      interval_timer_irq <= 1'b0;
      waveform_timer_irq <= 1'b0;
      #1;
   endtask : fire

   task automatic st(input logic c, input logic f, input logic [7:0] p);
      chk({6'h0, cpu_clk_en, fast_osc_en}, {6'h0, c, f});
      chk(snooze_status_pin, p);
   endtask : st

   task automatic rx_frame();
      @(posedge sys_clk);
      serial_rx_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      serial_rx_pin <= 1'b1;
   endtask : rx_frame

   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      wt(3);
      // values after reset, the two unmapped places included
      for (int i = 0; i < 8; i++) begin
         rd_chk(3'(i), rst_tab[i]);
      end
      st(1'b1, 1'b1, 8'h00);
      chk({7'h0, range_high}, 8'h01);
      chk({7'h0, slow_osc_en}, 8'h01);
      // a trigger while running starts nothing
      wr_reg(ctrl_off, 8'h09);
      fire(1);
      wt(3);
      chk(8'(n_conv), 8'h00);
      wr_reg(upper_off, 8'h80);
      wr_reg(lower_off, 8'h20);
      fire(0);
      wt(2);
      st(1'b0, 1'b0, 8'h00);
      chk({7'h0, wdt_osc_en}, 8'h00);
      rd_chk(status_off, 8'h4C);
      // one conversion per status pin, results on the window edges
      for (int i = 0; i < 8; i++) begin
         wr_reg(ctrl_off, {1'b0, 3'(i), 4'h9});
         conv_value <= i[0] ? 8'h80 : 8'h20;
         fire(1);
         st(1'b0, 1'b1, 8'h01 << i);
         rd_chk(status_off, 8'h2C);
         wt(lat + 4);
         st(1'b0, 1'b0, 8'h00);
      end
      chk(8'(n_conv), 8'h08);
      chk(8'(n_ci), 8'h00);
      // wake by a high result, active low on pin 7, then a low result
      for (int k = 0; k < 2; k++) begin
         wr_reg(ctrl_off, k ? 8'h09 : 8'h71);
         if (k) fire(0);
         wt(1);
         conv_value <= k ? 8'h1F : 8'h81;
         chk(snooze_status_pin, k ? 8'h00 : 8'hFF);
         fire(2 - k);
         st(1'b0, 1'b1, k ? 8'h01 : 8'h7F);
         wt(lat + 4);
         st(1'b1, 1'b1, k ? 8'h00 : 8'hFF);
         chk({7'h0, wdt_osc_en}, 8'h01);
         wr_reg(ctrl_off, 8'h08);
      end
      chk(8'(n_ci), 8'h02);
      chk(8'(n_wc), 8'h02);
      // serial wake: an edge while running is flagged, then miss and match
      wr_reg(cmp_off, 8'h55);
      wr_reg(ctrl_off, 8'h0E);
      rx_frame();
      wt(6);
      rd_chk(status_off, 8'h0F);
      wr_reg(status_off, 8'h02);
      rd_chk(status_off, 8'h0D);
      fire(0);
      for (int k = 0; k < 2; k++) begin
         rx_value <= k ? 8'h55 : 8'h33;
         rx_frame();
         wt(lat + 12);
         chk({7'h0, cpu_clk_en}, 8'(k));
         chk(8'(n_si), 8'(k));
      end
      chk(8'(n_rx), 8'h02);
      rd_chk(rxdata_off, 8'h55);
      rd_chk(status_off, 8'h0D);
      // drop the mode request and wait for its status before the enable
      wr_reg(ctrl_off, 8'h0A);
      rv = 8'h01;
      for (int n = 0; n < 8 && rv[st_mode_bit]; n++) begin
         rd_reg(status_off, rv);
      end
      chk(rv, 8'h0C);
      wr_reg(ctrl_off, 8'h08);
      // transfer keeps the cpu asleep; the external pin wakes it from stop, then from snooze
      wr_reg(ctrl_off, 8'h88);
      for (int k = 0; k < 2; k++) begin
         fire(0);
         fire(1);
         st(1'b0, 1'b1, 8'h01);
         @(posedge sys_clk);
         external_pin_irq <= k[0];
         wt(lat + 3);
         st(k[0], k[0], 8'h00);
         @(posedge sys_clk);
         external_pin_irq <= 1'b1;
         repeat (8) @(posedge sys_clk);
         external_pin_irq <= 1'b0;
         // the synchronised pin must be low again before the next stop
         wt(6);
         st(1'b1, 1'b1, 8'h00);
      end
      chk(8'(n_xfer), 8'h02);
      // reset in mid conversion, with new option straps caught after it
      wr_reg(ctrl_off, 8'h09);
      fire(0);
      fire(1);
      @(posedge sys_clk);
      rst <= 1'b1;
      wd_sb_opt <= 1'b1;
      range_opt <= 1'b0;
      @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      st(1'b1, 1'b1, 8'h00);
      wt(2);
      rd_chk(ctrl_off, 8'h08);
      rd_chk(status_off, 8'h18);
      chk({7'h0, range_high}, 8'h00);
      // a watchdog left running through stop is not cleared on wake
      fire(0);
      wt(2);
      chk({7'h0, wdt_osc_en}, 8'h01);
      @(posedge sys_clk);
      external_pin_irq <= 1'b1;
      wt(8);
      st(1'b1, 1'b1, 8'h00);
      chk(8'(n_wc), 8'h05);
      close_out();
   end
endmodule : tb
